// ==== hw/gpc_pkg.sv ====
// Package holding types and constants for the GPIO pin control block
package gpc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int GPC_NUM_PINS   = 10;
    localparam int GPC_NUM_SRC    = 8;
    localparam int GPC_SEL_W      = 3;

    // ------------------------------------------------------------------
    // Drive mode codes (three bits, eight codes, seven modes)
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        GPC_DM_INPUT_ONLY   = 3'h0,
        GPC_DM_WEAKUP_STRDN = 3'h1,
        GPC_DM_STRUP_WEAKDN = 3'h2,
        GPC_DM_OD_STRDN     = 3'h3,
        GPC_DM_OD_STRUP     = 3'h4,
        GPC_DM_STRONG       = 3'h5,
        GPC_DM_WEAK         = 3'h6,
        GPC_DM_SPARE        = 3'h7
    } gpc_drive_mode_type;

    // ------------------------------------------------------------------
    // Reset values: every pin disabled
    // ------------------------------------------------------------------
    localparam logic [2:0] GPC_RST_MODE  = 3'h0;
    localparam logic       GPC_RST_BIT   = 1'b0;

    // ------------------------------------------------------------------
    // Per-pin configuration carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] drive_mode;     // Drive mode code
        logic       lvttl_sel;      // 1: LVTTL threshold, 0: CMOS
        logic       in_buf_en;      // Input buffer enable
        logic       out_buf_en;     // Output buffer enable
        logic       slow_slew;      // 1: slow edge rate
        logic       amux_sw;        // Connect to analog mux bus
        logic [2:0] route_sel;      // Routing matrix source select
    } gpc_pin_cfg_type;

    // Pin drive state as presented to the pad
    typedef struct packed {
        logic pull_up_strong;
        logic pull_up_weak;
        logic pull_dn_strong;
        logic pull_dn_weak;
        logic oe;
        logic out;
        logic ie;
        logic lvttl;
        logic slow;
        logic amux;
    } gpc_pad_ctl_type;

endpackage : gpc_pkg

// ==== hw/gpc_pad_cell.sv ====
// One pin cell: decodes drive mode, holds state while hold is active
`timescale 1ns/1ps
`default_nettype none
module gpc_pad_cell (
    input  wire logic                     core_clk_in,
    input  wire logic                     reset_n_in,
    input  wire gpc_pkg::gpc_pin_cfg_type cfg_in,
    input  wire logic                     out_val_in,
    input  wire logic                     hold_in,
    output var  gpc_pkg::gpc_pad_ctl_type pad_out
);
    import gpc_pkg::*;

    typedef struct packed {
        gpc_pad_ctl_type pad;
    } gpc_cell_state_type;

    gpc_cell_state_type state;
    gpc_cell_state_type next_state;
    gpc_pad_ctl_type    decoded;

    // ------------------------------------------------------------------
    // Drive mode decode
    // ------------------------------------------------------------------
    always_comb begin
        decoded       = '0;
        decoded.ie    = cfg_in.in_buf_en;
        decoded.lvttl = cfg_in.lvttl_sel;
        decoded.slow  = cfg_in.slow_slew;
        decoded.amux  = cfg_in.amux_sw;
        decoded.out   = out_val_in;
        // Output buffer gate acts on top of the drive mode
        if (cfg_in.out_buf_en) begin
            case (gpc_drive_mode_type'(cfg_in.drive_mode))
                GPC_DM_WEAKUP_STRDN: begin
                    decoded.pull_up_weak   = out_val_in;
                    decoded.pull_dn_strong = !out_val_in;
                end
                GPC_DM_STRUP_WEAKDN: begin
                    decoded.pull_up_strong = out_val_in;
                    decoded.pull_dn_weak   = !out_val_in;
                end
                GPC_DM_OD_STRDN: begin
                    decoded.pull_dn_strong = !out_val_in;
                end
                GPC_DM_OD_STRUP: begin
                    decoded.pull_up_strong = out_val_in;
                end
                GPC_DM_STRONG: begin
                    decoded.pull_up_strong = out_val_in;
                    decoded.pull_dn_strong = !out_val_in;
                end
                GPC_DM_WEAK: begin
                    decoded.pull_up_weak = out_val_in;
                    decoded.pull_dn_weak = !out_val_in;
                end
                default: begin
                end
            endcase
        end
        decoded.oe = decoded.pull_up_strong | decoded.pull_dn_strong;
    end

    // ------------------------------------------------------------------
    // Hold latch: freeze whole pad state while hold is set
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (!hold_in) begin
            next_state.pad = decoded;
        end
    end

    // Reset forces the disabled pad state
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pad_out = state.pad;

    AST_HOLD_FREEZE: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        hold_in && $past(hold_in) |-> $stable(state.pad))
        else $error("Pad changed while hold active");

endmodule // gpc_pad_cell
`default_nettype wire

// ==== hw/gpc_pin_control.sv ====
// Top of the GPIO pin control block: routing matrix and per-pin cells
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_control #(
    parameter int NUM_PINS = gpc_pkg::GPC_NUM_PINS,
    parameter int NUM_SRC  = gpc_pkg::GPC_NUM_SRC
) (
    input  wire logic                     core_clk_in,
    input  wire logic                     reset_n_in,
    input  wire gpc_pkg::gpc_pin_cfg_type cfg_in       [NUM_PINS],
    input  wire logic [NUM_SRC-1:0]       periph_sig_in,
    input  wire logic [NUM_PINS-1:0]      i2c_pin_in,
    input  wire logic                     hold_in,
    input  wire logic [NUM_PINS-1:0]      pad_level_in,
    input  wire logic                     cc_amux_req_in,
    output var  gpc_pkg::gpc_pad_ctl_type pad_ctl_out  [NUM_PINS],
    output var  logic [NUM_PINS-1:0]      pin_level_out,
    output var  logic                     cc_amux_sw_out
);
    import gpc_pkg::*;

    // ------------------------------------------------------------------
    // State and routing
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0] level;
        logic                cc_amux;
    } gpc_top_state_type;

    gpc_top_state_type state;
    gpc_top_state_type next_state;
    logic [NUM_PINS-1:0] routed;
    gpc_pin_cfg_type     eff_cfg [NUM_PINS];

    // Routing matrix select; out-of-range source reads low
    function automatic logic route_pick(input logic [NUM_SRC-1:0] src,
                                        input logic [2:0] sel);
        route_pick = (int'(sel) < NUM_SRC) ? src[sel] : 1'b0;
    endfunction

    // ------------------------------------------------------------------
    // Per-pin cells (ten general pins incl. I2C and debug pins)
    // ------------------------------------------------------------------
    generate
        for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
            always_comb begin
                eff_cfg[p] = cfg_in[p];
                // I2C pins must not push high: force open-drain low side
                if (i2c_pin_in[p]) begin
                    eff_cfg[p].drive_mode = GPC_DM_OD_STRDN;
                end
            end
            assign routed[p] = route_pick(periph_sig_in,
                                          cfg_in[p].route_sel);
            gpc_pad_cell u_cell (
                .core_clk_in (core_clk_in),
                .reset_n_in  (reset_n_in),
                .cfg_in      (eff_cfg[p]),
                .out_val_in  (routed[p]),
                .hold_in     (hold_in),
                .pad_out     (pad_ctl_out[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Input capture; a disabled input buffer reads low
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        for (int p = 0; p < NUM_PINS; p++) begin
            next_state.level[p] = pad_level_in[p] & cfg_in[p].in_buf_en;
        end
        // Config-channel and pulldown pins have no mux switch at all
        next_state.cc_amux = 1'b0;
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pin_level_out  = state.level;
    assign cc_amux_sw_out = state.cc_amux;

    AST_CC_NO_AMUX: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        cc_amux_req_in |=> !cc_amux_sw_out)
        else $error("CC pin reached analog mux");

    AST_I2C_OD: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        i2c_pin_in[0] && !hold_in |=> !pad_ctl_out[0].pull_up_strong)
        else $error("I2C pin drove strong high");

    AST_IN_GATE: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        !cfg_in[0].in_buf_en |=> !pin_level_out[0])
        else $error("Disabled input buffer passed level");

    // ------------------------------------------------------------------
    // Per-pin checks
    // ------------------------------------------------------------------
    // Each pin is watched one cycle after its settings are taken. Most
    // checks look only while hold is low: a held pin may disagree with
    // its live settings until hold drops, which is the point of hold.
    // The bus flag overrides the drive mode, so mode checks exclude it; the open-drain low side check takes it in.
    // Pull checks name the weak pulls, not only the enable, so a stray weak pull is caught
    // even where the enable alone would still look right.
    generate
        for (genvar c = 0; c < NUM_PINS; c++) begin : g_chk
            // First edge after a reset release still shows the safe state
            AST_RESET_DISABLED: assert property (
                @(posedge core_clk_in)
                $rose(reset_n_in)
                |-> pad_ctl_out[c] == '0 && !pin_level_out[c])
                else $error("Pin not disabled after reset");

            // Never pull both ways at once, weak or strong: no crowbar
            AST_NO_FIGHT: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !((pad_ctl_out[c].pull_up_strong ||
                   pad_ctl_out[c].pull_up_weak) &&
                  (pad_ctl_out[c].pull_dn_strong ||
                   pad_ctl_out[c].pull_dn_weak)))
                else $error("Pin pulled both ways");

            // Output buffer off removes every pull, whatever the mode
            AST_OB_OFF: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !cfg_in[c].out_buf_en
                |=> !pad_ctl_out[c].oe && !pad_ctl_out[c].pull_up_weak &&
                    !pad_ctl_out[c].pull_dn_weak)
                else $error("Drive left with output buffer off");

            // Input buffer enable reaches the pad a cycle later
            AST_IE_FOLLOWS: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in
                |=> pad_ctl_out[c].ie == $past(cfg_in[c].in_buf_en))
                else $error("Input buffer enable not applied");

            // Threshold select reaches the pad a cycle later
            AST_LVTTL_FOLLOWS: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in
                |=> pad_ctl_out[c].lvttl == $past(cfg_in[c].lvttl_sel))
                else $error("Threshold select not applied");

            // Slew select reaches the pad a cycle later
            AST_SLEW_FOLLOWS: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in
                |=> pad_ctl_out[c].slow == $past(cfg_in[c].slow_slew))
                else $error("Slew select not applied");

            // Analog mux switch reaches the pad a cycle later
            AST_AMUX_FOLLOWS: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in
                |=> pad_ctl_out[c].amux == $past(cfg_in[c].amux_sw))
                else $error("Analog mux switch not applied");

            // Routed source value reaches the pad a cycle later
            AST_ROUTE_OUT: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in
                |=> pad_ctl_out[c].out ==
                    $past(route_pick(periph_sig_in, cfg_in[c].route_sel)))
                else $error("Routed value not on pad");

            // Input only drives nothing at all
            AST_INPUT_ONLY: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !i2c_pin_in[c] &&
                cfg_in[c].drive_mode == GPC_DM_INPUT_ONLY
                |=> !pad_ctl_out[c].oe && !pad_ctl_out[c].pull_up_weak &&
                    !pad_ctl_out[c].pull_dn_weak)
                else $error("Input-only pin drove");

            // The spare code behaves exactly like input only
            AST_SPARE_INPUT: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !i2c_pin_in[c] &&
                cfg_in[c].drive_mode == GPC_DM_SPARE
                |=> !pad_ctl_out[c].oe && !pad_ctl_out[c].pull_up_weak &&
                    !pad_ctl_out[c].pull_dn_weak)
                else $error("Spare code drove the pin");

            // Weak pull-up with strong pull-down follows the data
            AST_WEAK_UP_STRONG_DN: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !i2c_pin_in[c] && cfg_in[c].out_buf_en &&
                cfg_in[c].drive_mode == GPC_DM_WEAKUP_STRDN
                |=> pad_ctl_out[c].pull_up_weak == pad_ctl_out[c].out &&
                    pad_ctl_out[c].pull_dn_strong == !pad_ctl_out[c].out &&
                    !pad_ctl_out[c].pull_up_strong &&
                    !pad_ctl_out[c].pull_dn_weak)
                else $error("Weak-up strong-down decode wrong");

            // Strong pull-up with weak pull-down follows the data
            AST_STRONG_UP_WEAK_DN: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !i2c_pin_in[c] && cfg_in[c].out_buf_en &&
                cfg_in[c].drive_mode == GPC_DM_STRUP_WEAKDN
                |=> pad_ctl_out[c].pull_up_strong == pad_ctl_out[c].out &&
                    pad_ctl_out[c].pull_dn_weak == !pad_ctl_out[c].out &&
                    !pad_ctl_out[c].pull_up_weak &&
                    !pad_ctl_out[c].pull_dn_strong)
                else $error("Strong-up weak-down decode wrong");

            // Open drain low side only sinks, never lifts the pin
            AST_OD_SINK: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && cfg_in[c].out_buf_en &&
                (i2c_pin_in[c] || cfg_in[c].drive_mode == GPC_DM_OD_STRDN)
                |=> pad_ctl_out[c].pull_dn_strong == !pad_ctl_out[c].out &&
                    !pad_ctl_out[c].pull_up_strong &&
                    !pad_ctl_out[c].pull_up_weak &&
                    !pad_ctl_out[c].pull_dn_weak)
                else $error("Open-drain low side decode wrong");

            // Open drain high side only sources, never pulls low
            AST_OD_SOURCE: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !i2c_pin_in[c] && cfg_in[c].out_buf_en &&
                cfg_in[c].drive_mode == GPC_DM_OD_STRUP
                |=> pad_ctl_out[c].pull_up_strong == pad_ctl_out[c].out &&
                    !pad_ctl_out[c].pull_dn_strong &&
                    !pad_ctl_out[c].pull_up_weak &&
                    !pad_ctl_out[c].pull_dn_weak)
                else $error("Open-drain high side decode wrong");

            // Strong both ways drives whenever the output buffer is on, in the data's direction
            AST_STRONG_BOTH: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !i2c_pin_in[c] && cfg_in[c].out_buf_en &&
                cfg_in[c].drive_mode == GPC_DM_STRONG
                |=> pad_ctl_out[c].oe &&
                    pad_ctl_out[c].pull_up_strong == pad_ctl_out[c].out &&
                    pad_ctl_out[c].pull_dn_strong == !pad_ctl_out[c].out &&
                    !pad_ctl_out[c].pull_up_weak &&
                    !pad_ctl_out[c].pull_dn_weak)
                else $error("Strong drive decode wrong");

            // Weak both ways never drives strongly, only pulls
            AST_WEAK_BOTH: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && !i2c_pin_in[c] && cfg_in[c].out_buf_en &&
                cfg_in[c].drive_mode == GPC_DM_WEAK
                |=> !pad_ctl_out[c].oe &&
                    pad_ctl_out[c].pull_up_weak == pad_ctl_out[c].out &&
                    pad_ctl_out[c].pull_dn_weak == !pad_ctl_out[c].out)
                else $error("Weak drive decode wrong");

            // A bus pin never lifts its line, strong or weak
            AST_BUS_NO_HIGH: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !hold_in && i2c_pin_in[c]
                |=> !pad_ctl_out[c].pull_up_strong &&
                    !pad_ctl_out[c].pull_up_weak)
                else $error("Bus pin pulled high");

            // Held pad keeps its previous state on every field
            AST_HOLD_KEEP: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                hold_in && $past(hold_in)
                |-> $stable(pad_ctl_out[c]))
                else $error("Held pad changed");

            // A disabled input buffer reads low on every pin
            AST_LEVEL_GATE: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                !cfg_in[c].in_buf_en
                |=> !pin_level_out[c])
                else $error("Disabled input passed a level");

            // An enabled input buffer passes the pad level a cycle later
            AST_LEVEL_CAPTURE: assert property (
                @(posedge core_clk_in) disable iff (!reset_n_in)
                cfg_in[c].in_buf_en
                |=> pin_level_out[c] == $past(pad_level_in[c]))
                else $error("Pad level not captured");
        end
    endgenerate

endmodule // gpc_pin_control
`default_nettype wire

// ==== verif/gpc_ext_circuit.sv ====
// External circuit model that resolves the level seen on each pad
`timescale 1ns/1ps
`default_nettype none
module gpc_ext_circuit #(
    parameter int NUM_PINS = gpc_pkg::GPC_NUM_PINS
) (
    input  wire gpc_pkg::gpc_pad_ctl_type pad_ctl_in    [NUM_PINS],
    input  wire logic [NUM_PINS-1:0]      ext_level_in,
    output var  logic [NUM_PINS-1:0]      pad_level_out
);
    import gpc_pkg::*;
    // Driven pad wins, then weak pulls, else the outside level shows
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            if (pad_ctl_in[p].oe) begin
                pad_level_out[p] = pad_ctl_in[p].out;
            end else if (pad_ctl_in[p].pull_up_weak) begin
                pad_level_out[p] = 1'b1;
            end else if (pad_ctl_in[p].pull_dn_weak) begin
                pad_level_out[p] = 1'b0;
            end else begin
                pad_level_out[p] = ext_level_in[p];
            end
        end
    end
endmodule // gpc_ext_circuit
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the GPIO pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gpc_pkg::*;
    localparam int NP = GPC_NUM_PINS;
    logic                   core_clk_in = 1'b0;
    logic                   reset_n_in  = 1'b0;
    gpc_pin_cfg_type        cfg [NP];
    gpc_pad_ctl_type        pad [NP];
    logic [GPC_NUM_SRC-1:0] periph = '0;
    logic [NP-1:0]          i2c = '0, ext = '0, lvl, pin_lvl;
    logic                   hold = 1'b0, cc_req = 1'b0, cc_sw;
    logic [3:0]             drv;
    int                     fails = 0, n_checks = 0, cycles = 0;

    gpc_pin_control DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .cfg_in(cfg), .periph_sig_in(periph), .i2c_pin_in(i2c),
        .hold_in(hold), .pad_level_in(lvl), .cc_amux_req_in(cc_req),
        .pad_ctl_out(pad), .pin_level_out(pin_lvl), .cc_amux_sw_out(cc_sw));
    gpc_ext_circuit ext_model (.pad_ctl_in(pad), .ext_level_in(ext),
        .pad_level_out(lvl));

    // 10 MHz clock; the cycle ceiling cuts a hang short
    always #50 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Same setup on every pin; pin p listens to source p mod 8
    task automatic set_all(input logic [2:0] dm, input logic ob,
                           input logic ib, input logic [2:0] misc);
        for (int p = 0; p < NP; p++) begin
            cfg[p] = '{dm, misc[2], ib, ob, misc[1], misc[0],
                       3'(p % GPC_NUM_SRC)};
        end
    endtask
    // Expected pulls {strong up, weak up, strong down, weak down}
    function automatic logic [3:0] drive_exp(input int m, input logic v);
        case (m)
            1: drive_exp = v ? 4'h4 : 4'h2;
            2: drive_exp = v ? 4'h8 : 4'h1;
            3: drive_exp = v ? 4'h0 : 4'h2;
            4: drive_exp = v ? 4'h8 : 4'h0;
            5: drive_exp = v ? 4'h8 : 4'h2;
            6: drive_exp = v ? 4'h4 : 4'h1;
            default: drive_exp = 4'h0;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        set_all(3'h0, 1'b0, 1'b0, 3'h0);
        tick(6);
        check(pad[0], '0);
        reset_n_in = 1'b1;
        // Every code at both data levels: all four pulls, then the enable
        for (int m = 0; m < 8; m++) begin
            set_all(3'(m), 1'b1, 1'b0, 3'h0);
            for (int v = 0; v < 2; v++) begin
                periph = {GPC_NUM_SRC{v[0]}};
                tick(2);
                drv = drive_exp(m, v[0]);
                check(pad[0][9:6], drv);
                check(pad[0].oe, drv[3] | drv[1]);
            end
        end
        // Output buffer off removes all drive even in strong mode
        set_all(3'h5, 1'b0, 1'b0, 3'h0);
        tick(2);
        check(pad[0][9:5], 5'h00);
        // Input buffer gates the level seen from outside
        ext = 10'h2a5;
        set_all(3'h0, 1'b0, 1'b1, 3'h0);
        tick(3);
        check(pin_lvl, 10'h2a5);
        check(pad[0].ie, 1'b1);
        set_all(3'h0, 1'b0, 1'b0, 3'h7);
        cc_req = 1'b1;
        tick(3);
        check(pin_lvl, 10'h000);
        check(pad[0].ie, 1'b0);
        check(pad[9][2:0], 3'h7);
        check(cc_sw, 1'b0);
        cc_req = 1'b0;
        // Walk a single high source through the routing matrix
        set_all(3'h5, 1'b1, 1'b0, 3'h0);
        for (int k = 0; k < GPC_NUM_SRC; k++) begin
            periph = GPC_NUM_SRC'(1) << k;
            tick(2);
            for (int p = 0; p < NP; p++) begin
                check(pad[p].out, 1'(p % GPC_NUM_SRC == k));
            end
        end
        // Bus pins never pull strongly up, they only sink
        i2c = '1;
        periph = '1;
        tick(2);
        check({pad[0].pull_up_strong, pad[0].oe}, 2'h0);
        periph = '0;
        tick(2);
        check({pad[0].pull_dn_strong, pad[0].oe}, 2'h3);
        i2c = '0;
        // Hold freezes the pad while settings move underneath
        periph = '1;
        tick(2);
        hold = 1'b1;
        tick(1);
        periph = '0;
        set_all(3'h0, 1'b0, 1'b0, 3'h0);
        tick(3);
        check({pad[0].oe, pad[0].out}, 2'h3);
        hold = 1'b0;
        tick(2);
        check(pad[0].oe, 1'b0);
        // Reset in mid-run drops every pin straight away
        set_all(3'h5, 1'b1, 1'b1, 3'h7);
        periph = '1;
        tick(2);
        reset_n_in = 1'b0;
        #10;
        check(pad[3], '0);
        check(pin_lvl, 10'h000);
        // Release again on a falling edge: settings return one edge later
        tick(1);
        reset_n_in = 1'b1;
        tick(1);
        check({pad[3].oe, pad[3].ie, pad[3].out}, 3'h7);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
